// ==== bsvc_params.svh ====
/*
  constants of the serial vector control block: frame layout, op codes,
  vector table limits and reset values.
  assumes: included by bare name from the package only; the modules use its macros.
*/
`ifndef BSVC_PARAMS_SVH
`define BSVC_PARAMS_SVH

// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define BSVC_FRAME_BITS   16
`define BSVC_OP_MSB       15
`define BSVC_OP_LSB       14
`define BSVC_AMP_MSB      13
`define BSVC_AMP_LSB      6
`define BSVC_PHASE_MSB    5
`define BSVC_PHASE_LSB    0
`define BSVC_LAST_BIT_CNT 5'h0f
`define BSVC_FULL_CNT     5'h10

// ----------------------------------------------------------------------
// op codes
// ----------------------------------------------------------------------
`define BSVC_OP_WRITE     2'h0
`define BSVC_OP_READ      2'h1
`define BSVC_OP_PDOWN     2'h2
`define BSVC_OP_NOP       2'h3

// ----------------------------------------------------------------------
// vector table
// ----------------------------------------------------------------------
`define BSVC_QUARTER      6'h0c
`define BSVC_HALF         6'h18
`define BSVC_THREE_Q      6'h24
`define BSVC_WRAP         6'h30
`define BSVC_VEC_FS       6'h3f

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define BSVC_AMP_RST      8'h00
`define BSVC_PHASE_RST    6'h00

`endif

// ==== bsvc_pkg.sv ====
/*
  types shared by the serial vector control modules.
  assumes: bsvc_params.svh is on the include path.
*/
`include "bsvc_params.svh"

package bsvc_pkg;

  // --------------------------------------------------------------------
  // op codes and frame
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    BSVC_WRITE = `BSVC_OP_WRITE,
    BSVC_READ  = `BSVC_OP_READ,
    BSVC_PDOWN = `BSVC_OP_PDOWN,
    BSVC_NOP   = `BSVC_OP_NOP
  } bsvc_op_t;

  typedef struct packed {
    bsvc_op_t    op;
    logic [7:0]  amp;
    logic [5:0]  phase;
  } bsvc_frame_t;

  // --------------------------------------------------------------------
  // signed vector: sign and magnitude
  // --------------------------------------------------------------------
  typedef struct packed {
    logic        neg;
    logic [5:0]  mag;
  } bsvc_vec_t;

  // bit 0 is in-phase first, bit 3 quadrature second
  typedef struct packed {
    logic q_second;
    logic q_first;
    logic i_second;
    logic i_first;
  } bsvc_pwm_t;

  typedef struct packed {
    bsvc_vec_t cos_v;
    bsvc_vec_t sin_v;
  } bsvc_rom_t;

  typedef struct packed {
    logic [2:0]  tog_s;
    logic [2:0]  cs_s;
    logic [2:0]  ld_s;
    bsvc_pwm_t   pwm_s1;
    bsvc_pwm_t   pwm_s2;
    bsvc_frame_t frame;
    logic        frame_ok;
    logic [7:0]  buf_amp;
    logic [5:0]  buf_phase;
    logic [7:0]  act_amp;
    logic [5:0]  act_phase;
    logic        pd;
    logic        rd_active;
    logic [15:0] rb;
    logic [14:0] sink_a;
    logic [14:0] sink_b;
  } bsvc_state_t;

endpackage

// ==== bsvc_vector_rom.sv ====
/*
  angle to cosine and sine lookup with registered outputs.
  assumes: phase comes from logic on clk; one cycle of latency.
*/
`timescale 1ns/100ps
`default_nettype none

module bsvc_vector_rom (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [5:0]        phase,
  output bsvc_pkg::bsvc_rom_t    vec
);

  bsvc_pkg::bsvc_rom_t r;
  bsvc_pkg::bsvc_rom_t n;
  logic [5:0]          rem;
  logic [1:0]          quad;

  // ----------------------------------------------------------------------
  // quarter wave, round(63 * cos(r * 7.5 deg))
  // ----------------------------------------------------------------------
  function automatic logic [5:0] quarter_mag(input logic [5:0] idx);
    case (idx)
      6'h00:   quarter_mag = `BSVC_VEC_FS;
      6'h01:   quarter_mag = 6'h3e;
      6'h02:   quarter_mag = 6'h3d;
      6'h03:   quarter_mag = 6'h3a;
      6'h04:   quarter_mag = 6'h37;
      6'h05:   quarter_mag = 6'h32;
      6'h06:   quarter_mag = 6'h2d;
      6'h07:   quarter_mag = 6'h26;
      6'h08:   quarter_mag = 6'h20;
      6'h09:   quarter_mag = 6'h18;
      6'h0a:   quarter_mag = 6'h10;
      6'h0b:   quarter_mag = 6'h08;
      default: quarter_mag = 6'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // quadrant folding
  // ----------------------------------------------------------------------
  always_comb begin
    n    = r;
    rem  = phase;
    quad = 2'h0;
    if (phase >= `BSVC_THREE_Q) begin
      quad = 2'h3;
      rem  = phase - `BSVC_THREE_Q;
    end else if (phase >= `BSVC_HALF) begin
      quad = 2'h2;
      rem  = phase - `BSVC_HALF;
    end else if (phase >= `BSVC_QUARTER) begin
      quad = 2'h1;
      rem  = phase - `BSVC_QUARTER;
    end
    unique case (quad) // RULE_05
      2'h0: begin
        n.cos_v = '{neg: 1'b0, mag: quarter_mag(rem)};
        n.sin_v = '{neg: 1'b0, mag: quarter_mag(`BSVC_QUARTER - rem)};
      end
      2'h1: begin
        n.cos_v = '{neg: 1'b1, mag: quarter_mag(`BSVC_QUARTER - rem)};
        n.sin_v = '{neg: 1'b0, mag: quarter_mag(rem)};
      end
      2'h2: begin
        n.cos_v = '{neg: 1'b1, mag: quarter_mag(rem)};
        n.sin_v = '{neg: 1'b1, mag: quarter_mag(`BSVC_QUARTER - rem)};
      end
      2'h3: begin
        n.cos_v = '{neg: 1'b0, mag: quarter_mag(`BSVC_QUARTER - rem)};
        n.sin_v = '{neg: 1'b1, mag: quarter_mag(rem)};
      end
    endcase
    // code 48 folds to zero degrees; reserved codes give no current
    if (phase == `BSVC_WRAP) begin // RULE_05
      n.cos_v = '{neg: 1'b0, mag: `BSVC_VEC_FS};
      n.sin_v = '{neg: 1'b0, mag: 6'h00};
    end else if (phase > `BSVC_WRAP) begin
      n.cos_v = '{neg: 1'b0, mag: 6'h00};
      n.sin_v = '{neg: 1'b0, mag: 6'h00};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r <= '{cos_v: '{neg: 1'b0, mag: `BSVC_VEC_FS},
             sin_v: '{neg: 1'b0, mag: 6'h00}};
    end else begin
      r <= n;
    end
  end

  assign vec = r;

endmodule // bsvc_vector_rom

`default_nettype wire

// ==== bsvc_serial_ctrl.sv ====
/*
  serial control of a beamforming source driver: frame shifter on the
  serial clock, op decode, buffer and active code registers, vector
  weighting of the four pwm current paths.
  assumes: host keeps sck still while cs_n is high and leaves at least
  60 ns between cs_n rising and the next sck rise.
*/
// Function
// RULE_01: a frame is 16 bits: two op bits, eight amplitude bits msb first, six phase bits msb first.
// RULE_02: op 00 writes the input buffer, 01 arms read-back, 11 leaves all codes unchanged.
// RULE_03: chip select rising with op 10 powers down, with any other op powers up.
// RULE_04: the amplitude code scales the output current linearly from zero to full scale at 255.
// RULE_05: the phase code picks an angle of code times 7.5 degrees, with 48 folding to zero.
// RULE_06: the host writes no phase code above 48.
// RULE_07: at 45 degrees both vectors are 45 and both paths of one side together give the peak.
// RULE_08: a positive component drives the first sink output, a negative one the second.
// RULE_09: each path current is amplitude code times vector magnitude out of 63.
// RULE_10: chip select is active low and its rise moves the shifted frame into the buffer.
// RULE_11: a rise of the transfer strobe copies the buffer into the active registers.
// RULE_12: during read-back the serial output changes on each falling serial clock edge.
// RULE_13: the host drives the four pwm inputs that gate the current paths.
// RULE_14: serial data is taken msb first on rising sck while chip select is low.
`timescale 1ns/100ps
`default_nettype none

module bsvc_serial_ctrl (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  input  wire logic        transfer_strobe,
  input  wire logic        inphase_pwm_first,
  input  wire logic        inphase_pwm_second,
  input  wire logic        quad_pwm_first,
  input  wire logic        quad_pwm_second,
  output logic             sdo,
  output logic [14:0]      sink_output_first,
  output logic [14:0]      sink_output_second,
  output logic             power_down
);

  // ----------------------------------------------------------------------
  // link side, clocked by sck
  // ----------------------------------------------------------------------
  logic [4:0]             lnk_cnt_r;
  logic [14:0]            lnk_shift_r;
  bsvc_pkg::bsvc_frame_t  lnk_hold_r;
  logic                   lnk_tog_r;
  logic                   sdo_r;
  logic [3:0]             sdo_idx;

  // cs_n high clears the bit count so a short frame cannot misalign
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      lnk_cnt_r <= 5'h00;
    end else if (lnk_cnt_r != `BSVC_FULL_CNT) begin
      lnk_cnt_r <= lnk_cnt_r + 5'h01;
    end
  end

  // held word only changes after a full new frame, so clk can copy it
  always_ff @(posedge sck) begin
    if (!cs_n) begin
      lnk_shift_r <= {lnk_shift_r[13:0], sdi}; // RULE_14
      if (lnk_cnt_r == `BSVC_LAST_BIT_CNT) begin
        lnk_hold_r <= {lnk_shift_r, sdi}; // RULE_01
      end
    end
  end

  // ----------------------------------------------------------------------
  // frame toggle towards clk
  // ----------------------------------------------------------------------
  // sck stands still in reset, so only an asynchronous clear gives the
  // toggle a known start; the clk side synchroniser resets to the same 0
  always_ff @(posedge sck or negedge reset_n) begin
    if (!reset_n) begin
      lnk_tog_r <= 1'b0;
    end else if (!cs_n && (lnk_cnt_r == `BSVC_LAST_BIT_CNT)) begin
      lnk_tog_r <= ~lnk_tog_r; // RULE_10
    end
  end

  // ----------------------------------------------------------------------
  // read-back shifter on falling sck
  // ----------------------------------------------------------------------
  bsvc_pkg::bsvc_state_t r;
  bsvc_pkg::bsvc_state_t n;

  assign sdo_idx = 4'(`BSVC_FULL_CNT - lnk_cnt_r);

  // rb and rd_active only move just after cs_n rises, while sck is still
  always_ff @(negedge sck) begin
    if (r.rd_active) begin
      sdo_r <= r.rb[sdo_idx]; // RULE_12
    end else begin
      sdo_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // vector lookup
  // ----------------------------------------------------------------------
  bsvc_pkg::bsvc_rom_t vec;

  bsvc_vector_rom u_rom (
    .clk     (clk),
    .reset_n (reset_n),
    .phase   (r.act_phase),
    .vec     (vec)
  );

  // ----------------------------------------------------------------------
  // control on clk
  // ----------------------------------------------------------------------
  logic                  tog_edge;
  logic                  cs_rise;
  logic                  ld_rise;
  logic                  frame_ready;
  logic                  commit;
  logic [3:0]            op_hot;
  bsvc_pkg::bsvc_frame_t word;
  bsvc_pkg::bsvc_pwm_t   pwm_in;
  logic [13:0]           path_amt [4];
  logic [3:0]            path_to_b;
  logic [3:0]            path_on;
  logic [14:0]           acc_a;
  logic [14:0]           acc_b;

  assign pwm_in = '{q_second: quad_pwm_second,
                    q_first:  quad_pwm_first,
                    i_second: inphase_pwm_second,
                    i_first:  inphase_pwm_first};

  // ----------------------------------------------------------------------
  // op decode
  // ----------------------------------------------------------------------
  // one-hot so that every consumer reads a single bit
  function automatic logic [3:0] op_onehot(input bsvc_pkg::bsvc_op_t op);
    case (op)
      bsvc_pkg::BSVC_WRITE: op_onehot = 4'h1;
      bsvc_pkg::BSVC_READ:  op_onehot = 4'h2;
      bsvc_pkg::BSVC_PDOWN: op_onehot = 4'h4;
      bsvc_pkg::BSVC_NOP:   op_onehot = 4'h8;
      default:              op_onehot = 4'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // current paths
  // ----------------------------------------------------------------------
  // in-phase pair weighs cos, quadrature pair sin; the second pin of a
  // pair carries the vector with its sign turned
  for (genvar p = 0; p < 4; p++) begin : g_path
    bsvc_pkg::bsvc_vec_t pv;
    assign pv           = (p >= 2) ? vec.sin_v : vec.cos_v;
    assign path_amt[p]  = {6'h00, r.act_amp} * {8'h00, pv.mag}; // RULE_09
    assign path_to_b[p] = pv.neg ^ ((p % 2) == 1); // RULE_08
    assign path_on[p]   = r.pwm_s2[p] & ~r.pd; // RULE_07
  end

  always_comb begin
    n           = r;
    n.tog_s     = {r.tog_s[1:0], lnk_tog_r};
    n.cs_s      = {r.cs_s[1:0], cs_n};
    n.ld_s      = {r.ld_s[1:0], transfer_strobe};
    n.pwm_s1    = pwm_in;
    n.pwm_s2    = r.pwm_s1;
    tog_edge    = r.tog_s[2] ^ r.tog_s[1];
    cs_rise     = r.cs_s[1] & ~r.cs_s[2];
    ld_rise     = r.ld_s[1] & ~r.ld_s[2];
    word        = tog_edge ? lnk_hold_r : r.frame;
    frame_ready = tog_edge | r.frame_ok;
    if (tog_edge) begin
      n.frame    = lnk_hold_r;
      n.frame_ok = 1'b1;
    end
    // a frame counts only on the cs_n rise that ends it
    commit = cs_rise & frame_ready;
    op_hot = 4'h0;
    if (commit) begin // RULE_10
      op_hot      = op_onehot(word.op);
      n.frame_ok  = 1'b0;
      n.pd        = op_hot[2]; // RULE_03
      n.rd_active = op_hot[1]; // RULE_02
      // read, power down and no-op keep the buffer as it stands
      if (op_hot[0]) begin // RULE_02
        n.buf_amp   = word.amp;
        n.buf_phase = word.phase;
      end
    end
    if (ld_rise) begin // RULE_11
      n.act_amp   = r.buf_amp;
      n.act_phase = r.buf_phase;
    end
    n.rb = {n.pd, n.rd_active, n.buf_amp, n.buf_phase};
    // at most two paths meet on one sink, so 15 bits cannot overflow
    acc_a = 15'h0000;
    acc_b = 15'h0000;
    for (int p = 0; p < 4; p++) begin
      if (path_on[p]) begin // RULE_07
        if (path_to_b[p]) begin // RULE_08
          acc_b = acc_b + {1'b0, path_amt[p]}; // RULE_04
        end else begin
          acc_a = acc_a + {1'b0, path_amt[p]}; // RULE_04
        end
      end
    end
    n.sink_a = acc_a;
    n.sink_b = acc_b;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r           <= '0;
      r.cs_s      <= 3'h7;
      r.buf_amp   <= `BSVC_AMP_RST;
      r.buf_phase <= `BSVC_PHASE_RST;
      r.act_amp   <= `BSVC_AMP_RST;
      r.act_phase <= `BSVC_PHASE_RST;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign sdo                = sdo_r;
  assign sink_output_first  = r.sink_a;
  assign sink_output_second = r.sink_b;
  assign power_down         = r.pd;

endmodule // bsvc_serial_ctrl

`default_nettype wire

// ==== bsvc_serial_ctrl_monitor.sv ====
/*
  port checker for the serial vector control block.
  assumes: bound to bsvc_serial_ctrl; one clk domain with sync reset.
*/
`timescale 1ns/100ps
`default_nettype none

module bsvc_serial_ctrl_monitor (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        sck,
  input wire logic        cs_n,
  input wire logic        sdi,
  input wire logic        transfer_strobe,
  input wire logic        inphase_pwm_first,
  input wire logic        inphase_pwm_second,
  input wire logic        quad_pwm_first,
  input wire logic        quad_pwm_second,
  input wire logic        sdo,
  input wire logic [14:0] sink_output_first,
  input wire logic [14:0] sink_output_second,
  input wire logic        power_down
);
  // ------
  // helpers: cycles since select high, cycles with no input change
  // ------
  logic [3:0] cs_cnt_r;
  logic [3:0] quiet_r;
  logic [5:0] ins_d_r;
  logic [5:0] ins;
  logic       pwm_off;
  assign ins = {cs_n, transfer_strobe, inphase_pwm_first,
                inphase_pwm_second, quad_pwm_first, quad_pwm_second};
  assign pwm_off = ins[3:0] == 4'h0;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cs_cnt_r <= 4'h0;
      quiet_r  <= 4'h0;
    end else begin
      cs_cnt_r <= !cs_n ? 4'h0 : cs_cnt_r + {3'h0, cs_cnt_r != 4'hf};
      quiet_r  <= ins != ins_d_r ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
    end
    ins_d_r <= ins;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_reset_clears: assert property (!$past(reset_n) |->
    sink_output_first == 15'h0 && sink_output_second == 15'h0 && !power_down)
    else $error("outputs not cleared by reset");
  a_pd_silent: assert property (power_down && $past(power_down) |->
    sink_output_first == 15'h0 && sink_output_second == 15'h0)
    else $error("current flows while powered down");
  a_pd_rise_frame: assert property ($rose(power_down) |->
    cs_cnt_r inside {[4'h1:4'h7]}) else $error("power down without frame end");
  a_pd_fall_frame: assert property ($fell(power_down) && $past(reset_n) |->
    cs_n && $past(cs_cnt_r) < 4'h7) else $error("power up without frame end");
  a_peak_first: assert property (sink_output_first <= 15'h59a6)
    else $error("first sink above peak");
  a_peak_second: assert property (sink_output_second <= 15'h59a6)
    else $error("second sink above peak");
  a_pwm_off_zero: assert property (pwm_off [*4] |->
    sink_output_first == 15'h0 && sink_output_second == 15'h0)
    else $error("current with all pwm inputs low");
  a_quiet_stable: assert property (quiet_r >= 4'h8 |->
    $stable(sink_output_first) && $stable(sink_output_second) && $stable(power_down))
    else $error("outputs moved without a cause");
endmodule // bsvc_serial_ctrl_monitor

bind bsvc_serial_ctrl bsvc_serial_ctrl_monitor i_mon (.clk(clk),
  .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .sdi(sdi),
  .transfer_strobe(transfer_strobe), .inphase_pwm_first(inphase_pwm_first),
  .inphase_pwm_second(inphase_pwm_second), .quad_pwm_first(quad_pwm_first),
  .quad_pwm_second(quad_pwm_second), .sdo(sdo),
  .sink_output_first(sink_output_first),
  .sink_output_second(sink_output_second), .power_down(power_down));

`default_nettype wire

// ==== bsvc_host_model.sv ====
/*
  host side of the serial link: sends frames, gathers read-back bits.
  assumes: send is called from the bench; sck is 30 ns, idle low.
*/
`timescale 1ns/100ps
`default_nettype none

module bsvc_host_model (
  output logic sck,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  // non-blocking, so the select's first rise reaches the block's
  // asynchronous bit-count clear whatever the start-up order
  initial begin
    sck  <= 1'b0;
    cs_n <= 1'b1;
    sdi  <= 1'b0;
  end

  // short frames (n < 16) are how the bench exercises refusal
  task automatic send(input logic [15:0] f, input int n, output logic [15:0] rd);
    #3.3 cs_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      sdi = f[i];
      #15 sck = 1'b1;
      rd = {rd[14:0], sdo};
      #15 sck = 1'b0;
    end
    #12 rd = {rd[14:0], sdo};
    sdi = ~sdi; // no pull on sdi: never leave the last bit standing
    #3 cs_n = 1'b1;
    #90;
  endtask
endmodule // bsvc_host_model

`default_nettype wire

// ==== tb_top.sv ====
/*
  self-checking bench of the serial vector control block.
  assumes: bsvc_pkg compiled first; checker is bound by its own file.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  typedef struct packed {
    logic        rd;
    logic [15:0] rb;
    logic [14:0] f;
    logic [14:0] s;
    logic        pd;
  } bsvc_note_t;
  logic        clk, reset_n, ld, sdo, pd, sck, cs_n, sdi;
  logic [3:0]  pw;
  logic [14:0] sf, ss;
  logic [15:0] rd_w;
  bsvc_note_t  q[$];
  int          fail_count, n_tests;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  bsvc_host_model i_host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  bsvc_serial_ctrl i_dut (.clk(clk), .reset_n(reset_n), .sck(sck),
    .cs_n(cs_n), .sdi(sdi), .transfer_strobe(ld),
    .inphase_pwm_first(pw[0]), .inphase_pwm_second(pw[1]),
    .quad_pwm_first(pw[2]), .quad_pwm_second(pw[3]), .sdo(sdo),
    .sink_output_first(sf), .sink_output_second(ss), .power_down(pd));

  // ------
  // helpers
  // ------
  task automatic check(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("errors %0d checks %0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic void expect_sinks(input int a, ph, input logic [3:0] w,
                                       output int f, s);
    int t[13] = '{63, 62, 61, 58, 55, 50, 45, 38, 32, 24, 16, 8, 0};
    int c, sn, qd, r;
    int v[4];
    qd = (ph % 48) / 12;
    r = ph % 12;
    c = qd == 0 ? t[r] : qd == 1 ? -t[12-r] : qd == 2 ? -t[r] : t[12-r];
    sn = qd == 0 ? t[12-r] : qd == 1 ? t[r] : qd == 2 ? -t[12-r] : -t[r];
    v = '{c, -c, sn, -sn};
    f = 0;
    s = 0;
    foreach (v[j]) if (w[j]) begin
      if (v[j] > 0) f += a * v[j];
      else s -= a * v[j];
    end
  endfunction

  task automatic note(input logic r, input int a, ph, input logic p);
    int f, s;
    expect_sinks(a, ph, pw, f, s);
    if (p) begin
      f = 0;
      s = 0;
    end
    q.push_back('{r, {p, 1'b1, 8'(a), 6'(ph)}, 15'(f), 15'(s), p});
  endtask

  task automatic drain;
    int i;
    for (i = 0; i < 300 && q.size() > 0; i++) @(posedge clk);
    if (q.size() > 0) begin
      fail_count++;
      print_verdict();
    end
  endtask

  task automatic frame(input logic [1:0] op, input logic [7:0] a,
                       input logic [5:0] ph, input int n);
    @(posedge clk);
    i_host.send({op, a, ph}, n, rd_w);
  endtask

  task automatic strobe;
    @(posedge clk) ld <= 1'b1;
    repeat (3) @(posedge clk);
    ld <= 1'b0;
  endtask

  // outputs settle within a dozen cycles of the last cause
  initial begin : watch
    bsvc_note_t n;
    forever begin
      @(posedge clk);
      if (q.size() > 0) begin
        repeat (12) @(posedge clk);
        n = q.pop_front();
        if (n.rd) check("readback", rd_w, n.rb);
        else begin
          check("sink_first", 16'(sf), 16'(n.f));
          check("sink_second", 16'(ss), 16'(n.s));
          check("power_down", 16'(pd), 16'(n.pd));
        end
      end
    end
  end

  initial begin
    int k, a;
    reset_n <= 1'b0;
    ld = 1'b0;
    pw = 4'h0;
    void'($urandom(9));
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    for (k = 0; k <= 48; k++) begin
      a = k == 6 ? 255 : k == 7 ? 0 : $urandom % 256;
      frame(2'h0, 8'(a), 6'(k), 16);
      @(posedge clk) pw <= k == 6 ? 4'h5 : 4'($urandom);
      strobe();
      note(1'b0, a, k, 1'b0);
      drain();
    end
    @(posedge clk) pw <= 4'h1;
    frame(2'h0, 8'h5a, 6'h09, 16);
    frame(2'h1, 8'hff, 6'h21, 16);
    frame(2'h3, 8'h11, 6'h22, 16);
    note(1'b1, 'h5a, 9, 1'b0);
    drain();
    strobe();
    note(1'b0, 'h5a, 9, 1'b0);
    drain();
    frame(2'h2, 8'h00, 6'h00, 16);
    note(1'b0, 0, 0, 1'b1);
    drain();
    frame(2'h3, 8'h00, 6'h00, 8);
    note(1'b0, 0, 0, 1'b1);
    drain();
    frame(2'h3, 8'h00, 6'h00, 16);
    note(1'b0, 'h5a, 9, 1'b0);
    drain();
    print_verdict();
  end
endmodule // tb_top

`default_nettype wire
